// *** hw/lcd_cmd_decoder.sv ***
// command byte decoder for the lcd driver: drive mode, power save, addressing
// assumes wr_strobe is a one-cycle pulse on core_clk, already synchronised
//
// Overview of operation
// RL1: two-byte drive mode select, top bits
// RL2: host zeroes six low bits of selection
// RL3: drive mode resets to Mode2
// RL4: codes 11,00,01,10 map Mode1..Mode4
// RL5: all-on while display off enters saver
// RL6: saver picks sleep or standby by indicator
// RL7: ram and modes kept during saver
// RL8: sleep stops oscillator and lcd supply
// RL9: sleep halts drive, outputs at vdd
// RL10: standby stops supply, oscillator keeps running
// RL11: standby halts scanning, indicator continues
// RL12: reset command in standby enters sleep
// RL13: blanking output low during power saver
// RL14: host avoids test; nop or reset clears
// RL15: nop changes nothing except clearing test
// RL16: host refreshes modes periodically
// RL17: 01xxxxxx loads display start line
// RL18: 1011xxxx loads page address
// RL19: 0001xxxx loads column upper nibble
// RL20: 0000xxxx loads column lower nibble
// RL21: mode-set byte locks until companion byte
`timescale 1ns/10ps
module lcd_cmd_decoder (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       wr_strobe,
  input  wire logic       cmd_data_select,
  input  wire logic [7:0] wr_data,
  output logic      [1:0] drive_mode,
  output logic      [5:0] start_line,
  output logic      [3:0] page_addr,
  output logic      [7:0] column_addr,
  output logic            display_on,
  output logic            all_points_on,
  output logic            indicator_on,
  output logic            test_mode,
  output logic            power_save,
  output logic            sleep_mode,
  output logic            standby_mode,
  output logic            osc_enable,
  output logic            lcd_supply_enable,
  output logic            duty_drive_enable,
  output logic            static_drive_enable,
  output logic            blanking_out_n
);
  logic                       cmd_stb;
  logic [1:0]                 drive_reg;
  logic [1:0]                 drive_next;
  logic [5:0]                 line_reg;
  logic [5:0]                 line_next;
  logic [3:0]                 page_reg;
  logic [3:0]                 page_next;
  logic [7:0]                 col_reg;
  logic [7:0]                 col_next;
  logic                       disp_reg;
  logic                       disp_next;
  logic                       allon_reg;
  logic                       allon_next;
  logic                       ind_reg;
  logic                       ind_next;
  logic                       test_reg;
  logic                       test_next;
  lcd_cmd_pkg::pending_t      pend_reg;
  lcd_cmd_pkg::pending_t      pend_next;
  logic                       enter_req;
  logic                       exit_req;
  logic                       reset_cmd;
  lcd_cmd_pkg::power_state_t  pstate;

  assign cmd_stb = wr_strobe && !cmd_data_select;

  always_comb begin
    drive_next = drive_reg;
    line_next  = line_reg;
    page_next  = page_reg;
    col_next   = col_reg;
    disp_next  = disp_reg;
    allon_next = allon_reg;
    ind_next   = ind_reg;
    test_next  = test_reg;
    pend_next  = pend_reg;
    enter_req  = 1'b0;
    exit_req   = 1'b0;
    reset_cmd  = 1'b0;
    if (cmd_stb) begin
      if (pend_reg == lcd_cmd_pkg::PEND_DRIVE) begin
        // six low bits are ignored; host is expected to send zeros
        drive_next = wr_data[7:6]; // RL1 RL4
        pend_next  = lcd_cmd_pkg::PEND_NONE; // RL21
      end else if (pend_reg == lcd_cmd_pkg::PEND_OTHER) begin
        // companion data of a neighbour's two-byte command, stored elsewhere
        pend_next = lcd_cmd_pkg::PEND_NONE; // RL21
      end else if (test_reg) begin
        // only nop or reset leave test mode; all else is swallowed
        if (wr_data == lcd_cmd_pkg::OP_NOP) begin
          test_next = 1'b0; // RL15
        end else if (wr_data == lcd_cmd_pkg::OP_RESET) begin
          // reset in test mode still homes the addresses, same as outside it
          test_next = 1'b0;
          reset_cmd = 1'b1; // RL12
          line_next = lcd_cmd_pkg::START_LINE_RESET;
          page_next = lcd_cmd_pkg::PAGE_RESET;
          col_next  = lcd_cmd_pkg::COLUMN_RESET;
        end
      end else if (wr_data == lcd_cmd_pkg::OP_DRIVE_MODE_SET) begin
        pend_next = lcd_cmd_pkg::PEND_DRIVE; // RL1 RL21
      end else if (wr_data == lcd_cmd_pkg::OP_VOL_MODE_SET || wr_data == lcd_cmd_pkg::OP_BLINK_MODE_SET) begin
        pend_next = lcd_cmd_pkg::PEND_OTHER; // RL21
      end else if (wr_data == lcd_cmd_pkg::OP_IND_ON) begin
        ind_next  = 1'b1;
        pend_next = lcd_cmd_pkg::PEND_OTHER; // RL21
      end else if (wr_data == lcd_cmd_pkg::OP_IND_OFF) begin
        ind_next = 1'b0;
      end else if (wr_data == lcd_cmd_pkg::OP_NOP) begin
        test_next = 1'b0; // RL15
      end else if (wr_data[7:4] == lcd_cmd_pkg::OP_TEST_HI || wr_data == lcd_cmd_pkg::OP_TEST_B) begin
        test_next = 1'b1;
      end else if (wr_data == lcd_cmd_pkg::OP_RESET) begin
        // internal reset: addresses home, ram and drive mode untouched
        reset_cmd = 1'b1; // RL12
        line_next = lcd_cmd_pkg::START_LINE_RESET;
        page_next = lcd_cmd_pkg::PAGE_RESET;
        col_next  = lcd_cmd_pkg::COLUMN_RESET;
      end else if (wr_data == lcd_cmd_pkg::OP_DISP_OFF) begin
        disp_next = 1'b0;
      end else if (wr_data == lcd_cmd_pkg::OP_DISP_ON) begin
        disp_next = 1'b1;
        exit_req  = 1'b1;
      end else if (wr_data == lcd_cmd_pkg::OP_ALL_ON) begin
        allon_next = 1'b1;
        enter_req  = !disp_reg; // RL5
      end else if (wr_data == lcd_cmd_pkg::OP_ALL_NORMAL) begin
        allon_next = 1'b0;
        exit_req   = 1'b1;
      end else if (wr_data[7:6] == lcd_cmd_pkg::OP_START_LINE_HI) begin
        line_next = wr_data[5:0]; // RL17
      end else if (wr_data[7:4] == lcd_cmd_pkg::OP_PAGE_HI) begin
        page_next = wr_data[3:0]; // RL18
      end else if (wr_data[7:4] == lcd_cmd_pkg::OP_COL_UPPER_HI) begin
        col_next = {wr_data[3:0], col_reg[3:0]}; // RL19
      end else if (wr_data[7:4] == lcd_cmd_pkg::OP_COL_LOWER_HI) begin
        col_next = {col_reg[7:4], wr_data[3:0]}; // RL20
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_reg <= lcd_cmd_pkg::DRIVE_MODE_RESET; // RL3
      line_reg  <= lcd_cmd_pkg::START_LINE_RESET;
      page_reg  <= lcd_cmd_pkg::PAGE_RESET;
      col_reg   <= lcd_cmd_pkg::COLUMN_RESET;
      disp_reg  <= 1'b0;
      allon_reg <= 1'b0;
      ind_reg   <= 1'b0;
      test_reg  <= 1'b0;
      pend_reg  <= lcd_cmd_pkg::PEND_NONE;
    end else begin
      drive_reg <= drive_next;
      line_reg  <= line_next;
      page_reg  <= page_next;
      col_reg   <= col_next;
      disp_reg  <= disp_next;
      allon_reg <= allon_next;
      ind_reg   <= ind_next;
      test_reg  <= test_next;
      pend_reg  <= pend_next;
    end
  end

  lcd_power_ctrl u_power (
    .core_clk     (core_clk),
    .rst          (rst),
    .enter_req    (enter_req),
    .exit_req     (exit_req),
    .reset_cmd    (reset_cmd),
    .indicator_on (ind_reg),
    .state        (pstate)
  );

  // saver only gates the oscillator, supply, drive enables and blanking; mode registers keep their values
  assign drive_mode          = drive_reg; // RL7
  assign start_line          = line_reg;
  assign page_addr           = page_reg;
  assign column_addr         = col_reg;
  assign display_on          = disp_reg;
  assign all_points_on       = allon_reg;
  assign indicator_on        = ind_reg;
  assign test_mode           = test_reg;
  assign sleep_mode          = (pstate == lcd_cmd_pkg::PWR_SLEEP);
  assign standby_mode        = (pstate == lcd_cmd_pkg::PWR_STANDBY);
  assign power_save          = sleep_mode || standby_mode;
  assign osc_enable          = !sleep_mode; // RL8 RL10
  assign lcd_supply_enable   = !power_save; // RL8 RL10
  assign duty_drive_enable   = !power_save; // RL9 RL11
  assign static_drive_enable = !sleep_mode; // RL9 RL11
  assign blanking_out_n      = !power_save; // RL13

  sequence s_drive_set;
    cmd_stb && pend_reg == lcd_cmd_pkg::PEND_NONE && !test_reg && wr_data == lcd_cmd_pkg::OP_DRIVE_MODE_SET;
  endsequence

  // companion byte taken while the drive lock stands, however long the gap
  sequence s_drive_companion;
    cmd_stb && pend_reg == lcd_cmd_pkg::PEND_DRIVE;
  endsequence

  property p_drive_two_byte;
    @(posedge core_clk) disable iff (rst)
      s_drive_companion |=> drive_mode == $past(wr_data[7:6]);
  endproperty
  a_drive_two_byte: assert property (p_drive_two_byte) else $error("drive mode not loaded"); // RL1

  property p_drive_lock;
    @(posedge core_clk) disable iff (rst)
      s_drive_set |=> (pend_reg == lcd_cmd_pkg::PEND_DRIVE && $stable(line_reg) && $stable(page_reg));
  endproperty
  a_drive_lock: assert property (p_drive_lock) else $error("drive set did not lock"); // RL21

  property p_locked_ignores;
    @(posedge core_clk) disable iff (rst)
      (pend_reg != lcd_cmd_pkg::PEND_NONE && cmd_stb) |=>
        (pend_reg == lcd_cmd_pkg::PEND_NONE && $stable(col_reg) && $stable(disp_reg));
  endproperty
  a_locked_ignores: assert property (p_locked_ignores) else $error("locked byte decoded"); // RL21

  property p_reset_mode2;
    @(posedge core_clk) $fell(rst) |-> drive_mode == lcd_cmd_pkg::DRIVE_MODE2;
  endproperty
  a_reset_mode2: assert property (p_reset_mode2) else $error("drive mode not mode2 after reset"); // RL3

  property p_enter_saver;
    @(posedge core_clk) disable iff (rst)
      (cmd_stb && pend_reg == lcd_cmd_pkg::PEND_NONE && !test_reg && wr_data == lcd_cmd_pkg::OP_ALL_ON
       && !disp_reg && !power_save) |=> (power_save && (standby_mode == $past(ind_reg)));
  endproperty
  a_enter_saver: assert property (p_enter_saver) else $error("saver not entered correctly"); // RL5

  property p_sleep_halts;
    @(posedge core_clk) disable iff (rst)
      sleep_mode |-> (!osc_enable && !lcd_supply_enable && !duty_drive_enable && !static_drive_enable);
  endproperty
  a_sleep_halts: assert property (p_sleep_halts) else $error("sleep left circuits running"); // RL8

  property p_standby_keeps_osc;
    @(posedge core_clk) disable iff (rst)
      standby_mode |-> (osc_enable && !lcd_supply_enable && !duty_drive_enable && static_drive_enable);
  endproperty
  a_standby_keeps_osc: assert property (p_standby_keeps_osc) else $error("standby enables wrong"); // RL10

  property p_blank_low;
    @(posedge core_clk) disable iff (rst)
      $rose(power_save) |-> !blanking_out_n;
  endproperty
  a_blank_low: assert property (p_blank_low) else $error("blanking not low in saver"); // RL13

  property p_nop_clears_only_test;
    @(posedge core_clk) disable iff (rst)
      (cmd_stb && pend_reg == lcd_cmd_pkg::PEND_NONE && wr_data == lcd_cmd_pkg::OP_NOP) |=>
        (!test_reg && $stable(drive_reg) && $stable(col_reg) && $stable(page_reg) && $stable(line_reg));
  endproperty
  a_nop_clears_only_test: assert property (p_nop_clears_only_test) else $error("nop changed state"); // RL15

  property p_page_load;
    @(posedge core_clk) disable iff (rst)
      (cmd_stb && pend_reg == lcd_cmd_pkg::PEND_NONE && !test_reg
       && wr_data[7:4] == lcd_cmd_pkg::OP_PAGE_HI) |=> page_addr == $past(wr_data[3:0]);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page not loaded"); // RL18

  property p_col_upper;
    @(posedge core_clk) disable iff (rst)
      (cmd_stb && pend_reg == lcd_cmd_pkg::PEND_NONE && !test_reg
       && wr_data[7:4] == lcd_cmd_pkg::OP_COL_UPPER_HI) |=> column_addr[7:4] == $past(wr_data[3:0]);
  endproperty
  a_col_upper: assert property (p_col_upper) else $error("column upper not loaded"); // RL19
endmodule : lcd_cmd_decoder

// *** hw/lcd_cmd_pkg.sv ***
// constants for the lcd command interpreter: opcodes, masks, reset values
// assumes command bytes arrive already qualified by cmd_data_select low
package lcd_cmd_pkg;
  localparam logic [7:0] OP_DRIVE_MODE_SET  = 8'hd2;
  localparam logic [7:0] OP_NOP             = 8'he3;
  localparam logic [7:0] OP_RESET           = 8'he2;
  localparam logic [7:0] OP_DISP_OFF        = 8'hae;
  localparam logic [7:0] OP_DISP_ON         = 8'haf;
  localparam logic [7:0] OP_ALL_ON          = 8'ha5;
  localparam logic [7:0] OP_ALL_NORMAL      = 8'ha4;
  localparam logic [7:0] OP_IND_OFF         = 8'hac;
  localparam logic [7:0] OP_IND_ON          = 8'had;
  localparam logic [7:0] OP_VOL_MODE_SET    = 8'h81;
  localparam logic [7:0] OP_BLINK_MODE_SET  = 8'hd5;
  localparam logic [7:0] OP_TEST_A          = 8'hd2;
  localparam logic [7:0] OP_TEST_B          = 8'hd4;
  localparam logic [3:0] OP_TEST_HI         = 4'hf;
  localparam logic [1:0] OP_START_LINE_HI   = 2'h1;
  localparam logic [3:0] OP_PAGE_HI         = 4'hb;
  localparam logic [3:0] OP_COL_UPPER_HI    = 4'h1;
  localparam logic [3:0] OP_COL_LOWER_HI    = 4'h0;
  localparam logic [1:0] DRIVE_MODE1        = 2'h3;
  localparam logic [1:0] DRIVE_MODE2        = 2'h0;
  localparam logic [1:0] DRIVE_MODE3        = 2'h1;
  localparam logic [1:0] DRIVE_MODE4        = 2'h2;
  localparam logic [1:0] DRIVE_MODE_RESET   = 2'h0;
  localparam logic [5:0] START_LINE_RESET   = 6'h00;
  localparam logic [3:0] PAGE_RESET         = 4'h0;
  localparam logic [7:0] COLUMN_RESET       = 8'h00;

  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_SLEEP   = 2'b01,
    PWR_STANDBY = 2'b10
  } power_state_t;

  typedef enum logic [1:0] {
    PEND_NONE  = 2'b00,
    PEND_DRIVE = 2'b01,
    PEND_OTHER = 2'b10
  } pending_t;
endpackage : lcd_cmd_pkg

// *** hw/lcd_power_ctrl.sv ***
// power saver state machine: normal, sleep, standby
// assumes one-cycle command strobes on core_clk
`timescale 1ns/10ps
module lcd_power_ctrl (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      enter_req,
  input  wire logic                      exit_req,
  input  wire logic                      reset_cmd,
  input  wire logic                      indicator_on,
  output lcd_cmd_pkg::power_state_t      state
);
  lcd_cmd_pkg::power_state_t state_reg;
  lcd_cmd_pkg::power_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      lcd_cmd_pkg::PWR_NORMAL: begin
        if (enter_req) begin
          state_next = indicator_on ? lcd_cmd_pkg::PWR_STANDBY : lcd_cmd_pkg::PWR_SLEEP; // RL6
        end
      end
      lcd_cmd_pkg::PWR_SLEEP: begin
        if (exit_req) begin
          state_next = lcd_cmd_pkg::PWR_NORMAL;
        end
      end
      lcd_cmd_pkg::PWR_STANDBY: begin
        if (reset_cmd) begin
          state_next = lcd_cmd_pkg::PWR_SLEEP; // RL12
        end else if (exit_req) begin
          state_next = lcd_cmd_pkg::PWR_NORMAL;
        end
      end
      default: state_next = lcd_cmd_pkg::PWR_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= lcd_cmd_pkg::PWR_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;

  property p_standby_reset_sleeps;
    @(posedge core_clk) disable iff (rst)
      (state_reg == lcd_cmd_pkg::PWR_STANDBY && reset_cmd) |=> (state_reg == lcd_cmd_pkg::PWR_SLEEP);
  endproperty
  a_standby_reset_sleeps: assert property (p_standby_reset_sleeps) else $error("standby reset not sleep"); // RL12
endmodule : lcd_power_ctrl

// *** testbench/lcd_host_model.sv ***
// host side model: writes command and data bytes on the parallel write port
// assumes the decoder takes a byte on the rising edge where wr_strobe is high
`timescale 1ns/10ps
module lcd_host_model (
  input  wire logic       core_clk,
  output logic            wr_strobe,
  output logic            cmd_data_select,
  output logic      [7:0] wr_data
);
  initial begin
    wr_strobe       = 1'b0;
    cmd_data_select = 1'b1;
    wr_data         = 8'h00;
  end

  // selection byte of a drive mode: low six bits always zero
  function automatic logic [7:0] drive_sel(input logic [1:0] mode);
    return {mode, 6'h00};
  endfunction : drive_sel

  // a quiet cycle after each byte so every answer is seen on its own
  task automatic send(input logic sel, input logic [7:0] b);
    @(posedge core_clk);
    #1;
    cmd_data_select = sel;
    wr_data         = b;
    wr_strobe       = 1'b1;
    @(posedge core_clk);
    #1;
    wr_strobe       = 1'b0;
    cmd_data_select = 1'b1;
    wr_data         = ~b;
    @(posedge core_clk);
  endtask : send
endmodule : lcd_host_model

// *** testbench/test_lcd_cmd_decoder.sv ***
// self-checking bench for the lcd command decoder
// assumes the host model drives the write port; notes are checked one cycle after each strobe
`timescale 1ns/10ps
module test_lcd_cmd_decoder;
  logic        core_clk;
  logic        rst;
  wire         wr_strobe;
  wire         cmd_data_select;
  wire  [7:0]  wr_data;
  wire  [31:0] seen;
  logic [31:0] notes[$];
  logic [1:0]  codes[4] = '{lcd_cmd_pkg::DRIVE_MODE1, lcd_cmd_pkg::DRIVE_MODE3,
                            lcd_cmd_pkg::DRIVE_MODE4, lcd_cmd_pkg::DRIVE_MODE2};
  logic [1:0]  e_drive, e_pwr, e_lock;
  logic [5:0]  e_line;
  logic [3:0]  e_page;
  logic [7:0]  e_col;
  logic        e_don, e_apon, e_ind, e_test;
  int          n_errors = 0;
  int          n_compared = 0;
  int          seed = 74;
  logic [31:0] r;
  string       tname = "reset";

  lcd_host_model host (.core_clk(core_clk), .wr_strobe(wr_strobe), .cmd_data_select(cmd_data_select),
                       .wr_data(wr_data));

  lcd_cmd_decoder uut (.core_clk(core_clk), .rst(rst), .wr_strobe(wr_strobe), .cmd_data_select(cmd_data_select),
    .wr_data(wr_data), .drive_mode(seen[31:30]), .start_line(seen[29:24]), .page_addr(seen[23:20]),
    .column_addr(seen[19:12]), .display_on(seen[11]), .all_points_on(seen[10]), .indicator_on(seen[9]),
    .test_mode(seen[8]), .power_save(seen[7]), .sleep_mode(seen[6]), .standby_mode(seen[5]),
    .osc_enable(seen[4]), .lcd_supply_enable(seen[3]), .duty_drive_enable(seen[2]),
    .static_drive_enable(seen[1]), .blanking_out_n(seen[0]));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic init_model();
    e_drive = lcd_cmd_pkg::DRIVE_MODE_RESET;
    e_line  = lcd_cmd_pkg::START_LINE_RESET;
    e_page  = lcd_cmd_pkg::PAGE_RESET;
    e_col   = lcd_cmd_pkg::COLUMN_RESET;
    {e_don, e_apon, e_ind, e_test, e_pwr, e_lock} = 8'h00;
  endtask : init_model

  // power state: 0 normal, 1 sleep, 2 standby
  function automatic logic [31:0] snap();
    logic n, sl;
    n  = (e_pwr == 2'h0);
    sl = (e_pwr == 2'h1);
    return {e_drive, e_line, e_page, e_col, e_don, e_apon, e_ind, e_test,
            !n, sl, (e_pwr == 2'h2), !sl, n, n, !sl, n};
  endfunction : snap

  task automatic step(input logic sel, input logic [7:0] b);
    if (sel === 1'b1) begin
    end else if (e_lock != 2'h0) begin
      if (e_lock == 2'h1) e_drive = b[7:6];
      e_lock = 2'h0;
    end else if (e_test && b != lcd_cmd_pkg::OP_NOP && b != lcd_cmd_pkg::OP_RESET) begin
    end else if (b == lcd_cmd_pkg::OP_RESET) begin
      e_test = 1'b0;
      e_line = 6'h00;
      e_page = 4'h0;
      e_col  = 8'h00;
      if (e_pwr == 2'h2) e_pwr = 2'h1;
    end else if (b == lcd_cmd_pkg::OP_NOP) e_test = 1'b0;
    else if (b[7:6] == 2'h1) e_line = b[5:0];
    else if (b[7:4] == 4'hb) e_page = b[3:0];
    else if (b[7:4] == 4'h1) e_col[7:4] = b[3:0];
    else if (b[7:4] == 4'h0) e_col[3:0] = b[3:0];
    else if (b[7:4] == 4'hf || b == lcd_cmd_pkg::OP_TEST_B) e_test = 1'b1;
    else case (b)
      lcd_cmd_pkg::OP_DRIVE_MODE_SET: e_lock = 2'h1;
      lcd_cmd_pkg::OP_VOL_MODE_SET, lcd_cmd_pkg::OP_BLINK_MODE_SET: e_lock = 2'h2;
      lcd_cmd_pkg::OP_IND_ON: begin
        e_ind  = 1'b1;
        e_lock = 2'h2;
      end
      lcd_cmd_pkg::OP_IND_OFF: e_ind = 1'b0;
      lcd_cmd_pkg::OP_DISP_OFF: e_don = 1'b0;
      lcd_cmd_pkg::OP_DISP_ON: begin
        e_don = 1'b1;
        e_pwr = 2'h0;
      end
      lcd_cmd_pkg::OP_ALL_NORMAL: begin
        e_apon = 1'b0;
        e_pwr  = 2'h0;
      end
      lcd_cmd_pkg::OP_ALL_ON: begin
        e_apon = 1'b1;
        if (!e_don) e_pwr = e_ind ? 2'h2 : 2'h1;
      end
      default: ;
    endcase
  endtask : step

  task automatic put(input logic sel, input logic [7:0] b);
    step(sel, b);
    notes.push_back(snap());
    host.send(sel, b);
  endtask : put

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // scoreboard: oldest note against outputs one cycle after each taken byte
  initial begin
    forever begin
      @(posedge core_clk);
      if (wr_strobe === 1'b1) begin
        @(posedge core_clk);
        #2;
        if (notes.size() == 0) check("note queue", 32'h1, 32'h0);
        else check(tname, notes.pop_front(), seen);
      end
    end
  end

  initial begin
    #400000;
    n_errors++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    init_model();
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    check(tname, snap(), seen);
    $display("end of test %s", tname);
    tname = "drive";
    for (int i = 0; i < 4; i++) begin
      put(1'b0, lcd_cmd_pkg::OP_DRIVE_MODE_SET);
      put(1'b0, host.drive_sel(codes[i]));
    end
    put(1'b0, lcd_cmd_pkg::OP_DRIVE_MODE_SET);
    put(1'b0, 8'hb5);
    put(1'b0, lcd_cmd_pkg::OP_VOL_MODE_SET);
    put(1'b0, 8'h47);
    put(1'b0, lcd_cmd_pkg::OP_BLINK_MODE_SET);
    put(1'b0, 8'h47);
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    init_model();
    check(tname, snap(), seen);
    $display("end of test %s", tname);
    tname = "address";
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      put(1'b0, {2'h1, r[5:0]});
      put(1'b0, {4'hb, r[9:6]});
      put(1'b0, {4'h1, r[13:10]});
      put(1'b0, {4'h0, r[17:14]});
      put(1'b1, r[31:24]);
    end
    $display("end of test %s", tname);
    tname = "sleep";
    put(1'b0, lcd_cmd_pkg::OP_IND_OFF);
    put(1'b0, lcd_cmd_pkg::OP_DISP_OFF);
    put(1'b0, lcd_cmd_pkg::OP_ALL_ON);
    put(1'b1, 8'h5a);
    put(1'b0, 8'hb3);
    put(1'b0, lcd_cmd_pkg::OP_DISP_ON);
    $display("end of test %s", tname);
    tname = "standby";
    put(1'b0, lcd_cmd_pkg::OP_IND_ON);
    put(1'b0, 8'h03);
    put(1'b0, lcd_cmd_pkg::OP_DISP_OFF);
    put(1'b0, lcd_cmd_pkg::OP_ALL_ON);
    put(1'b0, lcd_cmd_pkg::OP_RESET);
    put(1'b0, lcd_cmd_pkg::OP_ALL_NORMAL);
    $display("end of test %s", tname);
    tname = "test";
    put(1'b0, 8'hf5);
    put(1'b0, 8'h47);
    put(1'b0, lcd_cmd_pkg::OP_NOP);
    put(1'b0, lcd_cmd_pkg::OP_TEST_B);
    put(1'b0, 8'h4a);
    put(1'b0, lcd_cmd_pkg::OP_RESET);
    put(1'b0, lcd_cmd_pkg::OP_NOP);
    put(1'b0, lcd_cmd_pkg::OP_DRIVE_MODE_SET);
    put(1'b0, host.drive_sel(lcd_cmd_pkg::DRIVE_MODE3));
    $display("end of test %s", tname);
    for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge core_clk);
    if (notes.size() != 0) check("notes left", 32'h0, 32'(notes.size()));
    complete_run();
  end
endmodule : test_lcd_cmd_decoder
